// *** dv/flic_core_model.sv ***
// Core-side partner: takes offered interrupts and signals returns.
// Assumes level offers from the controller and one-cycle ack and return pulses.
`timescale 1ns/1ps
module flic_core_model (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_irq_req,
   input wire logic [15:0] i_irq_vector,
   input wire logic [1:0] i_irq_level,
   input wire logic [3:0] i_wait,
   input wire logic i_ret_req,
   output logic o_irq_ack,
   output logic o_irq_return,
   output logic [15:0] o_vec,
   output logic [1:0] o_lvl,
   output logic [7:0] o_taken
);
   logic [3:0] cnt;
   // ========================================
   // Acknowledge after i_wait cycles, only while the offer stands
   always_ff @(posedge i_clk_sys) begin
      if (i_reset || !i_irq_req || o_irq_ack) begin
         cnt <= 4'h0;
         o_irq_ack <= 1'b0;
      end else if (cnt == i_wait) begin
         o_irq_ack <= 1'b1;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
   // Record what was taken at the ack edge; pass return requests on
   always_ff @(posedge i_clk_sys) begin
      o_irq_return <= i_ret_req && !i_reset;
      if (i_reset) begin
         o_taken <= 8'h00;
      end else if (o_irq_ack && i_irq_req) begin
         o_vec <= i_irq_vector;
         o_lvl <= i_irq_level;
         o_taken <= o_taken + 8'h01;
      end
   end
endmodule

// *** dv/flic_top_assertions.sv ***
// Port checker for the interrupt controller, bound to its top module.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps
module flic_top_assertions
   import flic_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_WIDTH-1:0] i_paddr,
   input wire logic [DATA_WIDTH-1:0] i_pwdata,
   input wire logic [DATA_WIDTH-1:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic i_irq_ack,
   input wire logic o_irq_req,
   input wire logic [15:0] o_irq_vector,
   input wire logic [1:0] o_irq_level
);
   // ========================================
   // Properties
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   sequence s_taken;
      o_irq_req && i_irq_ack;
   endsequence
   sequence s_setup;
      i_psel && !i_penable;
   endsequence
   a_ack_drops: assert property (s_taken |=> !o_irq_req [*2])
      else $error("offer not withdrawn after ack");
   a_top_blocks: assert property (s_taken and o_irq_level == 2'h3 |=> !o_irq_req [*8])
      else $error("offer while top level in service");
   a_vector_map: assert property (o_irq_req |-> o_irq_vector[2:0] == 3'h3 && o_irq_vector <= 16'h0073)
      else $error("vector off the table");
   a_global_off: assert property (i_psel && i_penable && i_pwrite && i_paddr == 12'h2a0 &&
      !i_pwdata[7] |=> ##1 !o_irq_req)
      else $error("offer with global enable off");
   a_ready_up: assert property (!$past(i_reset) |-> o_pready)
      else $error("ready low after reset");
   a_bad_align: assert property (s_setup and i_paddr[1:0] != 2'h0 |=> o_pslverr && o_prdata == 32'h0)
      else $error("misaligned access not refused");
   a_read_upper: assert property (s_setup and !i_pwrite |=> o_prdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   a_idle_noerr: assert property (!i_psel |=> !o_pslverr)
      else $error("error flag held in idle");
endmodule
bind flic_top flic_top_assertions u_chk (.i_clk_sys, .i_reset, .i_psel, .i_penable, .i_pwrite,
   .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_irq_ack, .o_irq_req, .o_irq_vector,
   .o_irq_level);

// *** dv/tb.sv ***
// Self-checking bench for the interrupt controller: APB tasks and event stimulus.
// Assumes the core partner model and the bound port checker.
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0;
   logic rst, psel, pen, pwr, pready, pslverr, tick, ack, ret_p, req, retq;
   logic ta, tbo, asy, tw, adc;
   logic [1:0] pins, lvl, ml;
   logic [3:0] cap, wt;
   logic [11:0] paddr;
   logic [15:0] cnt16, vec, mv;
   logic [31:0] pwdata, prdata;
   logic [7:0] taken, nt, fa, fb, fc;
   int err_total = 0;
   int cmp_count = 0;
   logic [7:0] ri [6] = '{8'ha8, 8'he8, 8'hb8, 8'hb7, 8'hf8, 8'hf7};
   logic [7:0] rx [6] = '{8'hff, 8'hff, 8'h7f, 8'h7f, 8'hff, 8'hff};
   int po [15] = '{0, 5, 10, 1, 6, 11, 2, 7, 12, 3, 8, 13, 4, 9, 14};
   // ========================================
   // Clock, design and core partner
   always #20 clk = ~clk;
   flic_top u_dut (.i_clk_sys(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_ext_irq_pin_a(pins[0]), .i_ext_irq_pin_b(pins[1]),
      .i_timer_a_overflow(ta), .i_timer_b_overflow(tbo), .i_async_serial_event(asy),
      .i_twowire_status_load(tw), .i_adc_result_ready(adc), .i_capture_input(cap),
      .i_cc_tick(tick), .i_cc_count(cnt16), .i_irq_ack(ack), .i_irq_return(ret_p),
      .o_irq_req(req), .o_irq_vector(vec), .o_irq_level(lvl));
   flic_core_model u_core (.i_clk_sys(clk), .i_reset(rst), .i_irq_req(req), .i_irq_vector(vec),
      .i_irq_level(lvl), .i_wait(wt), .i_ret_req(retq), .o_irq_ack(ack), .o_irq_return(ret_p),
      .o_vec(mv), .o_lvl(ml), .o_taken(taken));
   // ========================================
   // Tasks
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   function automatic logic [11:0] ba(input logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (n >= 50) err_total++;
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      logic [31:0] q;
      logic e;
      apb(ba(i), 1'b1, {24'h0, d}, q, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic xe);
      logic [31:0] q;
      logic e;
      apb(a, 1'b0, 32'h0, q, e);
      chk(q, {24'h0, x});
      chk({31'h0, e}, {31'h0, xe});
   endtask
   // Wait for the core to take the next offer, then check vector and level
   task automatic take(input logic [15:0] v, input logic [1:0] l);
      int n;
      n = 0;
      nt = nt + 8'h01;
      while (taken !== nt && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk({24'h0, taken}, {24'h0, nt});
      chk({16'h0, mv}, {16'h0, v});
      chk({30'h0, ml}, {30'h0, l});
   endtask
   task automatic ret();
      @(posedge clk);
      retq <= 1'b1;
      @(posedge clk);
      retq <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic give_verdict();
      if (err_total == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ========================================
   // Watchdog
   initial begin
      #(40 * 20000);
      err_total++;
      give_verdict();
   end
   // ========================================
   // Main sequence
   initial begin
      {rst, psel, pen, pwr, ta, tbo, asy, tw, adc, tick, retq} = 11'h400;
      {pins, cap, wt, paddr, cnt16, pwdata, nt} = {2'b11, 76'h0};
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 6; k++) begin
         rd(ba(ri[k]), 8'h00, 1'b0);
         wr(ri[k], 8'hff);
         rd(ba(ri[k]), rx[k], 1'b0);
         wr(ri[k], 8'h00);
      end
      rd(ba(8'h00), 8'h00, 1'b1);
      wr(8'hd0, 8'h01);
      wr(8'hd1, 8'h02);
      wr(8'hd2, 8'h03);
      // Every hardware event once: pin falls, pulses, capture rises, four ticks
      @(posedge clk);
      {pins, ta, tbo, asy, tw, adc, cap} <= {2'b00, 5'h1f, 4'hf};
      @(posedge clk);
      {pins, ta, tbo, asy, tw, adc} <= {2'b11, 5'h00};
      for (int k = 1; k < 5; k++) begin
         tick <= 1'b1;
         cnt16 <= 16'(k % 4);
         @(posedge clk);
      end
      tick <= 1'b0;
      rd(ba(8'hc0), 8'h7f, 1'b0);
      rd(ba(8'hc8), 8'hff, 1'b0);
      rd(ba(8'hc9), 8'h03, 1'b0);
      wr(8'ha8, 8'h7f);
      rd(12'h2a1, 8'h00, 1'b1);
      wr(8'he8, 8'hff);
      repeat (6) @(posedge clk);
      chk({24'h0, taken}, 32'h0);
      wr(8'ha8, 8'hff);
      {fa, fb, fc} = {8'h7f, 8'h7f, 8'h03};
      for (int k = 0; k < 15; k++) begin
         take(16'h0003 + 16'(8 * po[k]), 2'h0);
         rd(ba(8'hc8), {|fc, fb[6:0]}, 1'b0);
         if (po[k] < 6) fa[po[k]] = 1'b0;
         else if (po[k] == 10) fa[6] = 1'b0;
         else if (po[k] < 10) fb[po[k] - 6] = 1'b0;
         else if (po[k] < 14) fb[po[k] - 7] = 1'b0;
         else fc = 8'h00;
         wr(8'hc0, fa);
         wr(8'hc8, fb);
         wr(8'hc9, fc);
         ret();
      end
      wr(8'hc0, 8'h40);
      rd(ba(8'hc0), 8'h00, 1'b0);
      // Levels 1, 2, 3 stacked by software-set flags, slow core
      wt <= 4'h3;
      wr(8'hb8, 8'h06);
      wr(8'hb7, 8'h05);
      wr(8'ha8, 8'h87);
      wr(8'hc0, 8'h02);
      take(16'h000b, 2'h1);
      wr(8'hc0, 8'h01);
      take(16'h0003, 2'h2);
      wr(8'hc0, 8'h04);
      take(16'h0013, 2'h3);
      rd(ba(8'hc4), 8'h0e, 1'b0);
      wr(8'hc0, 8'h0a);
      ret();
      rd(ba(8'hc4), 8'h06, 1'b0);
      ret();
      rd(ba(8'hc4), 8'h02, 1'b0);
      chk({24'h0, taken}, {24'h0, nt});
      ret();
      take(16'h000b, 2'h1);
      wr(8'hc0, 8'h08);
      ret();
      repeat (10) @(posedge clk);
      chk({24'h0, taken}, {24'h0, nt});
      give_verdict();
   end
endmodule

// *** pkg/flic_arb_if.sv ***
// Carrier between the controller and its level arbiter.
// Assumes both ends run in the same clock domain; the arbiter is purely combinational.
`timescale 1ns/1ps
interface flic_arb_if;
   import flic_pkg::*;

   logic [14:0] pending;
   flic_level_t level [SRC_COUNT];
   logic [3:0] in_service;
   logic grant_valid;
   flic_src_t grant_src;
   flic_level_t grant_level;

   modport ctrl (output pending, output level, output in_service,
                 input grant_valid, input grant_src, input grant_level);
   modport arb (input pending, input level, input in_service,
                output grant_valid, output grant_src, output grant_level);
endinterface

// *** pkg/flic_pkg.sv ***
// Constants, types and helpers for the four level interrupt controller.
// Assumes a 32-bit APB slave where each register index maps to byte address index*4.
package flic_pkg;

   // ==========================================================
   // Sizes
   localparam int unsigned SRC_COUNT = 15;
   localparam int unsigned LEVEL_COUNT = 4;
   localparam int unsigned ADDR_WIDTH = 12;
   localparam int unsigned DATA_WIDTH = 32;

   typedef logic [1:0] flic_level_t;
   typedef logic [3:0] flic_src_t;

   // ==========================================================
   // Register indices (byte address is four times the index)
   localparam logic [7:0] IDX_ENABLE_A = 8'ha8;
   localparam logic [7:0] IDX_ENABLE_B = 8'he8;
   localparam logic [7:0] IDX_PRIO_LOW_A = 8'hb8;
   localparam logic [7:0] IDX_PRIO_HIGH_A = 8'hb7;
   localparam logic [7:0] IDX_PRIO_LOW_B = 8'hf8;
   localparam logic [7:0] IDX_PRIO_HIGH_B = 8'hf7;
   localparam logic [7:0] IDX_FLAG_A = 8'hc0;
   localparam logic [7:0] IDX_FLAG_B = 8'hc8;
   localparam logic [7:0] IDX_FLAG_C = 8'hc9;
   localparam logic [7:0] IDX_IN_SERVICE = 8'hc4;
   localparam logic [7:0] IDX_CMP_A = 8'hd0;
   localparam logic [7:0] IDX_CMP_B = 8'hd1;
   localparam logic [7:0] IDX_CMP_C = 8'hd2;

   // ==========================================================
   // Field positions and reset values
   localparam int unsigned GLOBAL_EN_BIT = 7;
   localparam int unsigned ADC_BIT = 6;
   localparam int unsigned OVF_BIT = 7;
   localparam int unsigned CMP_LSB = 4;
   localparam int unsigned BYTE_OVF_BIT = 0;
   localparam int unsigned WORD_OVF_BIT = 1;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [15:0] CMP_RESET = 16'h0000;
   localparam logic [7:0] PRIO_A_MASK = 8'h7f;
   localparam logic [7:0] FLAG_A_MASK = 8'h7f;
   localparam logic [7:0] FLAG_B_MASK = 8'h7f;
   localparam logic [7:0] FLAG_C_MASK = 8'h03;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] WORD_ZERO = 16'h0000;

   // ==========================================================
   // Vectors: base plus eight bytes per source index
   localparam logic [15:0] VECTOR_BASE = 16'h0003;
   localparam logic [15:0] VECTOR_STEP = 16'h0008;

   // Same-level poll order, highest first, as source indices
   localparam flic_src_t POLL_ORDER [SRC_COUNT] = '{
      4'h0, 4'h5, 4'ha, 4'h1, 4'h6, 4'hb, 4'h2, 4'h7,
      4'hc, 4'h3, 4'h8, 4'hd, 4'h4, 4'h9, 4'he};

   // Spread the two register bytes onto source index order
   function automatic logic [14:0] flic_gather(input logic [7:0] a, input logic [7:0] b);
      flic_gather = {b[7], b[6:4], a[6], b[3:0], a[5:0]};
   endfunction

   // Vector address of a source
   function automatic logic [15:0] flic_vector(input flic_src_t src);
      flic_vector = VECTOR_BASE + VECTOR_STEP * {12'h000, src};
   endfunction

endpackage

// *** verilog/flic_arbiter.sv ***
// Level and poll-order arbiter for the interrupt controller.
// Assumes pending already carries enables and the global enable.
`timescale 1ns/1ps
module flic_arbiter
   import flic_pkg::*;
(
   flic_arb_if.arb bus
);

   // ==========================================================
   // Winner search: highest level first, then fixed poll order
   always_comb begin
      logic found;
      found = 1'b0;
      bus.grant_valid = 1'b0;
      bus.grant_src = 4'h0;
      bus.grant_level = 2'h0;
      for (int l = LEVEL_COUNT - 1; l >= 0; l--) begin
         for (int k = 0; k < SRC_COUNT; k++) begin
            // Only levels above everything in service may win (see RULE14) (see RULE15)
            if (!found && bus.pending[POLL_ORDER[k]] &&
                bus.level[POLL_ORDER[k]] == flic_level_t'(l) &&
                (bus.in_service >> l) == 4'h0) begin // see RULE20
               found = 1'b1;
               bus.grant_valid = 1'b1;
               bus.grant_src = POLL_ORDER[k];
               bus.grant_level = flic_level_t'(l);
            end
         end
      end
   end

endmodule

// *** verilog/flic_top.sv ***
// Four level nested interrupt controller with APB register access.
// Assumes all inputs are synchronous to i_clk_sys; the core acknowledges with one-cycle pulses.
//
// Overview of operation
// RULE1 - Fifteen sources, each any of four levels
// RULE2 - Timer block gives eight requests, overflows ORed
// RULE3 - Capture flags set by capture input edges
// RULE4 - Compare flags set on count equal compare
// RULE5 - Byte overflow and word overflow set flags
// RULE6 - Nine timer flags cleared only by software
// RULE7 - ADC request from sticky conversion-done flag
// RULE8 - Two-wire flag set on status load
// RULE9 - Software clears ADC flag, cannot set it
// RULE10 - Other flags software set and clear
// RULE11 - Per-source enable, zero masks, one allows
// RULE12 - Global enable bit gates every request
// RULE13 - High and low bits give level 0-3
// RULE14 - Grant only above every in-service level
// RULE15 - Higher level pre-empts lower in service
// RULE16 - First enable register layout at A8
// RULE17 - Second enable register layout at E8
// RULE18 - First priority-low register layout at B8
// RULE19 - Enable, low, high bits share positions
// RULE20 - Fixed poll order within a level
// RULE21 - Vectors from 0003 spaced eight bytes
// RULE22 - First priority-high register at B7
// RULE23 - Second priority-low register at F8
// RULE24 - In-service per level, return clears highest
`timescale 1ns/1ps
module flic_top
   import flic_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_WIDTH-1:0] i_paddr,
   input wire logic [DATA_WIDTH-1:0] i_pwdata,
   output logic [DATA_WIDTH-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_ext_irq_pin_a,
   input wire logic i_ext_irq_pin_b,
   input wire logic i_timer_a_overflow,
   input wire logic i_timer_b_overflow,
   input wire logic i_async_serial_event,
   input wire logic i_twowire_status_load,
   input wire logic i_adc_result_ready,
   input wire logic [3:0] i_capture_input,
   input wire logic i_cc_tick,
   input wire logic [15:0] i_cc_count,
   input wire logic i_irq_ack,
   input wire logic i_irq_return,
   output logic o_irq_req,
   output logic [15:0] o_irq_vector,
   output logic [1:0] o_irq_level
);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_OFFER = 3'b010,
      ST_SETTLE = 3'b100
   } flic_state_t;

   // ==========================================================
   // Storage
   logic [7:0] irq_enable_a;
   logic [7:0] irq_enable_b;
   logic [7:0] irq_priority_low_a;
   logic [7:0] irq_priority_high_a;
   logic [7:0] irq_priority_low_b;
   logic [7:0] irq_priority_high_b;
   logic [7:0] flag_a;
   logic [7:0] flag_b;
   logic [7:0] flag_c;
   logic [15:0] compare_value [3];
   logic [3:0] in_service;
   logic [3:0] capture_prev;
   logic ext_a_prev;
   logic ext_b_prev;
   flic_state_t state;

   logic [7:0] reg_index;
   logic addr_ok;
   logic wr_strobe;
   logic rd_setup;
   logic [7:0] wbyte;
   logic [7:0] hw_set_a;
   logic [7:0] hw_set_b;
   logic [7:0] hw_set_c;
   logic [7:0] flag_b_view;
   logic [14:0] flags_all;
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic [3:0] ret_mask;
   logic ack_taken;

   flic_arb_if arb_bus ();

   flic_arbiter u_arbiter (
      .bus(arb_bus)
   );

   // ==========================================================
   // APB decode
   assign reg_index = i_paddr[9:2];
   assign addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr[11:10] == 2'h0);
   assign wr_strobe = i_psel && i_penable && i_pwrite && addr_ok;
   assign rd_setup = i_psel && !i_penable;
   assign wbyte = i_pwdata[7:0];

   // Unmapped index check
   function automatic logic flic_mapped(input logic [7:0] idx);
      unique case (idx)
         IDX_ENABLE_A, IDX_ENABLE_B, IDX_PRIO_LOW_A, IDX_PRIO_HIGH_A,
         IDX_PRIO_LOW_B, IDX_PRIO_HIGH_B, IDX_FLAG_A, IDX_FLAG_B,
         IDX_FLAG_C, IDX_IN_SERVICE, IDX_CMP_A, IDX_CMP_B, IDX_CMP_C: flic_mapped = 1'b1;
         default: flic_mapped = 1'b0;
      endcase
   endfunction

   // ==========================================================
   // Hardware event detection
   always_comb begin
      hw_set_a = 8'h00;
      hw_set_b = 8'h00;
      hw_set_c = 8'h00;
      hw_set_a[0] = ext_a_prev && !i_ext_irq_pin_a;  // Falling edge on pin a
      hw_set_a[1] = i_timer_a_overflow;
      hw_set_a[2] = ext_b_prev && !i_ext_irq_pin_b;  // Falling edge on pin b
      hw_set_a[3] = i_timer_b_overflow;
      hw_set_a[4] = i_async_serial_event;
      hw_set_a[5] = i_twowire_status_load;  // see RULE8
      hw_set_a[ADC_BIT] = i_adc_result_ready;  // see RULE7
      hw_set_b[3:0] = i_capture_input & ~capture_prev;  // see RULE3
      for (int c = 0; c < 3; c++) begin
         // Match only when the count moves onto the compare value
         hw_set_b[CMP_LSB + c] = i_cc_tick && (i_cc_count == compare_value[c]);  // see RULE4
      end
      hw_set_c[BYTE_OVF_BIT] = i_cc_tick && (i_cc_count[7:0] == BYTE_ZERO);  // see RULE5
      hw_set_c[WORD_OVF_BIT] = i_cc_tick && (i_cc_count == WORD_ZERO);  // see RULE5
   end

   // Input history for edge detection
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         capture_prev <= 4'h0;
         ext_a_prev <= 1'b1;
         ext_b_prev <= 1'b1;
      end else begin
         capture_prev <= i_capture_input;
         ext_a_prev <= i_ext_irq_pin_a;
         ext_b_prev <= i_ext_irq_pin_b;
      end
   end

   // ==========================================================
   // Interrupt flags; a hardware set wins over a software clear
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         flag_a <= REG_RESET;
      end else if (wr_strobe && reg_index == IDX_FLAG_A) begin
         // Software writes the flags directly, except the ADC flag (see RULE10)
         flag_a <= FLAG_A_MASK & ((wbyte & ~(8'h01 << ADC_BIT)) | hw_set_a |
                   (flag_a & wbyte & (8'h01 << ADC_BIT)));  // see RULE9
      end else begin
         flag_a <= FLAG_A_MASK & (flag_a | hw_set_a);
      end
   end

   // Capture and compare flags, sticky until software clears them
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         flag_b <= REG_RESET;
      end else if (wr_strobe && reg_index == IDX_FLAG_B) begin
         flag_b <= FLAG_B_MASK & (wbyte | hw_set_b);  // see RULE10
      end else begin
         flag_b <= FLAG_B_MASK & (flag_b | hw_set_b);  // see RULE6
      end
   end

   // Overflow flags, sticky until software clears them
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         flag_c <= REG_RESET;
      end else if (wr_strobe && reg_index == IDX_FLAG_C) begin
         flag_c <= FLAG_C_MASK & (wbyte | hw_set_c);  // see RULE10
      end else begin
         flag_c <= FLAG_C_MASK & (flag_c | hw_set_c);  // see RULE6
      end
   end

   // Overflow request is the OR of the byte and word flags
   always_comb begin
      flag_b_view = flag_b;
      flag_b_view[OVF_BIT] = flag_c[BYTE_OVF_BIT] | flag_c[WORD_OVF_BIT];  // see RULE2
   end

   // ==========================================================
   // Enable and priority registers
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         irq_enable_a <= REG_RESET;
         irq_enable_b <= REG_RESET;
      end else if (wr_strobe) begin
         if (reg_index == IDX_ENABLE_A) begin
            irq_enable_a <= wbyte;  // see RULE16
         end
         if (reg_index == IDX_ENABLE_B) begin
            irq_enable_b <= wbyte;  // see RULE17
         end
      end
   end

   // Priority bits; bit 7 of the first pair is unused
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         irq_priority_low_a <= REG_RESET;
         irq_priority_high_a <= REG_RESET;
         irq_priority_low_b <= REG_RESET;
         irq_priority_high_b <= REG_RESET;
      end else if (wr_strobe) begin
         if (reg_index == IDX_PRIO_LOW_A) begin
            irq_priority_low_a <= wbyte & PRIO_A_MASK;  // see RULE18
         end
         if (reg_index == IDX_PRIO_HIGH_A) begin
            irq_priority_high_a <= wbyte & PRIO_A_MASK;  // see RULE22
         end
         if (reg_index == IDX_PRIO_LOW_B) begin
            irq_priority_low_b <= wbyte;  // see RULE23
         end
         if (reg_index == IDX_PRIO_HIGH_B) begin
            irq_priority_high_b <= wbyte;
         end
      end
   end

   // Compare values for the capture/compare timer
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         for (int c = 0; c < 3; c++) begin
            compare_value[c] <= CMP_RESET;
         end
      end else if (wr_strobe) begin
         if (reg_index == IDX_CMP_A) begin
            compare_value[0] <= i_pwdata[15:0];
         end
         if (reg_index == IDX_CMP_B) begin
            compare_value[1] <= i_pwdata[15:0];
         end
         if (reg_index == IDX_CMP_C) begin
            compare_value[2] <= i_pwdata[15:0];
         end
      end
   end

   // ==========================================================
   // Arbiter inputs
   assign flags_all = flic_gather(flag_a, flag_b_view);  // see RULE1
   // Per-source enables under the global enable (see RULE11) (see RULE12)
   assign arb_bus.pending = flags_all & flic_gather(irq_enable_a, irq_enable_b) &
                            {SRC_COUNT{irq_enable_a[GLOBAL_EN_BIT]}};
   assign arb_bus.in_service = in_service;

   // Level from matching high and low bits (see RULE13) (see RULE19)
   always_comb begin
      logic [14:0] lo;
      logic [14:0] hi;
      lo = flic_gather(irq_priority_low_a, irq_priority_low_b);
      hi = flic_gather(irq_priority_high_a, irq_priority_high_b);
      for (int s = 0; s < SRC_COUNT; s++) begin
         arb_bus.level[s] = {hi[s], lo[s]};
      end
   end

   // ==========================================================
   // Request offer to the core
   assign ack_taken = (state == ST_OFFER) && i_irq_ack;

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         state <= ST_IDLE;
         o_irq_req <= 1'b0;
         o_irq_vector <= VECTOR_BASE;
         o_irq_level <= 2'h0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (arb_bus.grant_valid) begin
                  state <= ST_OFFER;
                  o_irq_req <= 1'b1;
                  o_irq_vector <= flic_vector(arb_bus.grant_src);  // see RULE21
                  o_irq_level <= arb_bus.grant_level;
               end
            end
            ST_OFFER: begin
               if (i_irq_ack) begin
                  state <= ST_SETTLE;
                  o_irq_req <= 1'b0;
               end else if (!arb_bus.grant_valid) begin
                  // Request withdrawn by software or by a disable
                  state <= ST_IDLE;
                  o_irq_req <= 1'b0;
               end else begin
                  // Follow a better winner until the core takes one
                  o_irq_vector <= flic_vector(arb_bus.grant_src);
                  o_irq_level <= arb_bus.grant_level;
               end
            end
            ST_SETTLE: begin
               state <= ST_IDLE;  // Lets the new in-service level reach the arbiter
            end
         endcase
      end
   end

   // ==========================================================
   // In-service levels; return clears the highest one
   always_comb begin
      ret_mask = 4'h0;
      for (int l = 0; l < LEVEL_COUNT; l++) begin
         if (in_service[l]) begin
            ret_mask = 4'h1 << l;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         in_service <= 4'h0;
      end else begin
         // Nested levels stack; lower ones resume on return (see RULE15) (see RULE24)
         in_service <= (in_service & ~(i_irq_return ? ret_mask : 4'h0)) |
                       (ack_taken ? (4'h1 << o_irq_level) : 4'h0);
      end
   end

   // ==========================================================
   // APB read data, captured in the setup phase
   always_comb begin
      next_prdata = 32'h0000_0000;
      unique case (reg_index)
         IDX_ENABLE_A: next_prdata[7:0] = irq_enable_a;
         IDX_ENABLE_B: next_prdata[7:0] = irq_enable_b;
         IDX_PRIO_LOW_A: next_prdata[7:0] = irq_priority_low_a;
         IDX_PRIO_HIGH_A: next_prdata[7:0] = irq_priority_high_a;
         IDX_PRIO_LOW_B: next_prdata[7:0] = irq_priority_low_b;
         IDX_PRIO_HIGH_B: next_prdata[7:0] = irq_priority_high_b;
         IDX_FLAG_A: next_prdata[7:0] = flag_a;
         IDX_FLAG_B: next_prdata[7:0] = flag_b_view;
         IDX_FLAG_C: next_prdata[7:0] = flag_c;
         IDX_IN_SERVICE: next_prdata[3:0] = in_service;
         IDX_CMP_A: next_prdata[15:0] = compare_value[0];
         IDX_CMP_B: next_prdata[15:0] = compare_value[1];
         IDX_CMP_C: next_prdata[15:0] = compare_value[2];
         default: next_prdata = 32'h0000_0000;
      endcase
      next_pslverr = !(addr_ok && flic_mapped(reg_index));
   end

   // Zero wait state slave
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
         o_pready <= 1'b0;
      end else begin
         o_pready <= 1'b1;
         if (rd_setup) begin
            o_prdata <= (i_pwrite || next_pslverr) ? 32'h0000_0000 : next_prdata;
            o_pslverr <= next_pslverr;
         end else if (i_psel && i_penable) begin
            o_pslverr <= o_pslverr;
         end else begin
            o_pslverr <= 1'b0;
         end
      end
   end

endmodule
